// >>> verilog/bsci_pkg.sv
package bsci_pkg;

  // Instruction register width, capture pattern and opcodes.
  localparam int          IR_W         = 10;
  localparam logic [9:0]  IR_CAPTURE   = 10'h001;
  localparam logic [9:0]  OP_BYPASS    = 10'h3FF;
  localparam logic [9:0]  OP_SAMPLE    = 10'h005;
  localparam logic [9:0]  OP_IDCODE    = 10'h006;
  localparam logic [9:0]  OP_EXTEST    = 10'h00F;
  localparam logic [9:0]  OP_CLAMP     = 10'h00A;
  localparam logic [9:0]  OP_HIGHZ     = 10'h00B;
  localparam logic [9:0]  OP_CONFIG_IO = 10'h00D;
  localparam logic [9:0]  OP_PULSE_CFG = 10'h001;

  // Identification register; the default code is arbitrary.
  localparam int          ID_W         = 32;
  localparam logic [31:0] IDCODE_DEF   = 32'h0A5A_5001;

  // Boundary cell layout per pin: input, output data, output enable.
  localparam int          CELL_W       = 3;
  localparam int          CELL_IN      = 0;
  localparam int          CELL_OUT     = 1;
  localparam int          CELL_OE      = 2;

  // AHB-Lite register map, decoded on the low address bits.
  localparam int          DATA_W       = 32;
  localparam int          ADDR_W       = 8;
  localparam logic [7:0]  ADDR_CTRL    = 8'h00;
  localparam logic [7:0]  ADDR_OUTONLY = 8'h04;
  localparam logic [7:0]  ADDR_USEROUT = 8'h08;
  localparam logic [7:0]  ADDR_USEROE  = 8'h0C;
  localparam logic [7:0]  ADDR_STATUS  = 8'h10;
  localparam logic [7:0]  ADDR_PININ   = 8'h14;
  localparam int          CTRL_ALWAYS  = 0;
  localparam int          ST_W         = 4;
  localparam logic [2:0]  HSIZE_WORD   = 3'h2;
  localparam int          HTRANS_ACT   = 1;
  localparam logic        HRESP_OKAY   = 1'b0;

  // Configuration load time at the system clock rate.
  localparam int          CLK_NS         = 10;
  localparam int          CFG_TIME_NS    = 1000;
  localparam int          CFG_CYCLES_DEF = (CFG_TIME_NS + CLK_NS - 1) / CLK_NS;
  localparam int          CFG_CNT_W      = 16;

  // Test access port controller states.
  typedef enum logic [3:0] {
    TAP_TLR    = 4'h0,
    TAP_RTI    = 4'h1,
    TAP_SEL_DR = 4'h2,
    TAP_CAP_DR = 4'h3,
    TAP_SH_DR  = 4'h4,
    TAP_EX1_DR = 4'h5,
    TAP_PA_DR  = 4'h6,
    TAP_EX2_DR = 4'h7,
    TAP_UP_DR  = 4'h8,
    TAP_SEL_IR = 4'h9,
    TAP_CAP_IR = 4'hA,
    TAP_SH_IR  = 4'hB,
    TAP_EX1_IR = 4'hC,
    TAP_PA_IR  = 4'hD,
    TAP_EX2_IR = 4'hE,
    TAP_UP_IR  = 4'hF
  } bsci_tap_t;

  // Configuration engine states.
  typedef enum logic [1:0] {
    CFG_IDLE = 2'h0,
    CFG_LOAD = 2'h1,
    CFG_DONE = 2'h2,
    CFG_HALT = 2'h3
  } bsci_cfg_t;

endpackage : bsci_pkg

// >>> verilog/bsci_sync.sv
`timescale 1ns/10ps
`default_nettype none
module bsci_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  import bsci_pkg::*;

  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] q_d;

  // The first stage feeds only the second stage.
  always_comb begin
    meta_d = d;
    q_d    = meta_q;
  end

  // Two flip-flops per bit; each bit is an independent level.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= meta_d;
      q      <= q_d;
    end
  end

endmodule : bsci_sync
`default_nettype wire

// >>> verilog/bsci_top.sv
// Summary of operation
// - Scan port is always live, never disabled.
// - BYPASS, IDCODE, SAMPLE leave configuration running.
// - CONFIG_IO halts configuration, test owns I/O.
// - PULSE_CONFIG or request pulse restarts configuration.
// - Chip clear and enable never touch test.
// - Output-only input buffers off when configured.
// - SAMPLE turns output-only input buffers on.
// - Option keeps all input buffers always on.
// - Instruction capture shifts out 1 then 0.
// - Enable cell 0 drives data cell out.
// - All-ones opcode selects one-bit bypass path.
// - IDCODE loads and shifts 32-bit code.
//
// The AHB-Lite register port and the placing of the registers were decided locally.
`timescale 1ns/10ps
`default_nettype none
module bsci_top #(
  parameter int          NPIN       = 8,
  parameter logic [31:0] IDCODE_VAL = bsci_pkg::IDCODE_DEF,
  parameter int          CFG_CYCLES = bsci_pkg::CFG_CYCLES_DEF
) (
  input  wire logic                        mclk,
  input  wire logic                        rst,
  input  wire logic                        hsel,
  input  wire logic [31:0]                 haddr,
  input  wire logic [1:0]                  htrans,
  input  wire logic                        hwrite,
  input  wire logic [2:0]                  hsize,
  input  wire logic [bsci_pkg::DATA_W-1:0] hwdata,
  input  wire logic                        hready,
  output var  logic                        hreadyout,
  output var  logic                        hresp,
  output var  logic [bsci_pkg::DATA_W-1:0] hrdata,
  input  wire logic                        tck,
  input  wire logic                        tms,
  input  wire logic                        tdi,
  input  wire logic                        trst_n,
  output var  logic                        tdo,
  output var  logic                        tdo_oe_n,
  input  wire logic                        configuration_request_pin_n,
  input  wire logic                        chip_wide_clear_pin_n,
  input  wire logic                        chip_wide_output_enable_pin,
  input  wire logic [NPIN-1:0]             pin_in,
  output var  logic [NPIN-1:0]             pin_out,
  output var  logic [NPIN-1:0]             pin_oe_n,
  output var  logic [NPIN-1:0]             pin_ibuf_en
);
  import bsci_pkg::*;

  localparam int BW  = CELL_W * NPIN;
  localparam int T2M = 5 + 2 * NPIN;
  localparam int M2T = 4 * NPIN;
  localparam int P2M = NPIN + 3;

  logic                 tck_rst;
  bsci_tap_t            tap_q, tap_d;
  logic [IR_W-1:0]      ir_sh_q, ir_sh_d, ir_q, ir_d;
  logic                 tog_q, tog_d, sample_q, sample_d, cfgio_q, cfgio_d;
  logic                 drive_q, drive_d, highz_q, highz_d;
  logic                 bypass_q, bypass_d;
  logic [ID_W-1:0]      id_q, id_d;
  logic [BW-1:0]        bsr_q, bsr_d, upd_q, upd_d, cap_vec;
  logic                 sel_bsr, sel_id;
  logic                 tdo_q, tdo_d, tdo_oe_n_q, tdo_oe_n_d;
  logic [NPIN-1:0]      upd_out, upd_oe_n, pin_in_t, ibuf_t, uout_t, uoen_t;
  logic [T2M-1:0]       t2m_s;
  logic                 cfgio_s, tog_s, drive_s, highz_s, sample_s;
  logic [NPIN-1:0]      upd_out_s, upd_oe_s, pin_in_m;
  logic [P2M-1:0]       p2m_s;
  logic                 ncfg_s, clr_n_s, goe_s;
  logic                 tog_prev_q, pulse;
  bsci_cfg_t            cfg_q, cfg_d;
  logic [CFG_CNT_W-1:0] cnt_q, cnt_d;
  logic [NPIN-1:0]      pout_q, pout_d, poen_q, poen_d, ibuf_q, ibuf_d;
  logic                 always_q, always_d;
  logic [NPIN-1:0]      oonly_q, oonly_d, uout_q, uout_d, uoen_q, uoen_d;
  logic                 acc, wr_q, wr_d;
  logic [ADDR_W-1:0]    wa_q, wa_d;
  logic [DATA_W-1:0]    rd_q, rd_d, status_w;

  // The scan port reset comes only from the chip reset or the test reset pin.
  assign tck_rst = rst | ~trst_n;

  // Sixteen-state controller stepped by the mode select on each rising edge.
  always_comb begin : tap_next
    tap_d = tap_q;
    unique case (tap_q)
      TAP_TLR:    tap_d = tms ? TAP_TLR    : TAP_RTI;
      TAP_RTI:    tap_d = tms ? TAP_SEL_DR : TAP_RTI;
      TAP_SEL_DR: tap_d = tms ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: tap_d = tms ? TAP_EX1_DR : TAP_SH_DR;
      TAP_SH_DR:  tap_d = tms ? TAP_EX1_DR : TAP_SH_DR;
      TAP_EX1_DR: tap_d = tms ? TAP_UP_DR  : TAP_PA_DR;
      TAP_PA_DR:  tap_d = tms ? TAP_EX2_DR : TAP_PA_DR;
      TAP_EX2_DR: tap_d = tms ? TAP_UP_DR  : TAP_SH_DR;
      TAP_UP_DR:  tap_d = tms ? TAP_SEL_DR : TAP_RTI;
      TAP_SEL_IR: tap_d = tms ? TAP_TLR    : TAP_CAP_IR;
      TAP_CAP_IR: tap_d = tms ? TAP_EX1_IR : TAP_SH_IR;
      TAP_SH_IR:  tap_d = tms ? TAP_EX1_IR : TAP_SH_IR;
      TAP_EX1_IR: tap_d = tms ? TAP_UP_IR  : TAP_PA_IR;
      TAP_PA_IR:  tap_d = tms ? TAP_EX2_IR : TAP_PA_IR;
      TAP_EX2_IR: tap_d = tms ? TAP_UP_IR  : TAP_SH_IR;
      TAP_UP_IR:  tap_d = tms ? TAP_SEL_DR : TAP_RTI;
    endcase
  end

  // Instruction shift, update and the decoded flags that leave this domain.
  always_comb begin : ir_next
    ir_sh_d = ir_sh_q;
    ir_d    = ir_q;
    tog_d   = tog_q;
    if (tap_q == TAP_CAP_IR) begin
      ir_sh_d = IR_CAPTURE;
    end else if (tap_q == TAP_SH_IR) begin
      ir_sh_d = {tdi, ir_sh_q[IR_W-1:1]};
    end
    if (tap_q == TAP_UP_IR) begin
      ir_d = ir_sh_q;
      if (ir_sh_q == OP_PULSE_CFG) begin
        tog_d = ~tog_q;
      end
    end
    if (tap_q == TAP_TLR) begin
      ir_d = OP_IDCODE;
    end
    // Only CONFIG_IO and PULSE_CONFIG reach the configuration engine.
    cfgio_d  = (ir_d == OP_CONFIG_IO);
    sample_d = (ir_d == OP_SAMPLE);
    highz_d  = (ir_d == OP_HIGHZ);
    drive_d  = (ir_d == OP_EXTEST) | (ir_d == OP_CLAMP) | highz_d | cfgio_d;
  end

  // Data register path selection; unknown opcodes fall to the bypass bit.
  assign sel_bsr = (ir_q == OP_SAMPLE) | (ir_q == OP_EXTEST);
  assign sel_id  = (ir_q == OP_IDCODE);

  // Per-pin capture sources and update cell taps.
  for (genvar i = 0; i < NPIN; i++) begin : g_cell
    assign cap_vec[CELL_W*i+CELL_IN]  = pin_in_t[i] & ibuf_t[i];
    assign cap_vec[CELL_W*i+CELL_OUT] = uout_t[i];
    assign cap_vec[CELL_W*i+CELL_OE]  = uoen_t[i];
    assign upd_out[i]  = upd_q[CELL_W*i+CELL_OUT];
    assign upd_oe_n[i] = upd_q[CELL_W*i+CELL_OE];
  end

  // Capture, shift and update of bypass, identification and boundary registers.
  always_comb begin : dr_next
    bypass_d = bypass_q;
    id_d     = id_q;
    bsr_d    = bsr_q;
    upd_d    = upd_q;
    if (tap_q == TAP_CAP_DR) begin
      bypass_d = 1'b0;
      id_d     = IDCODE_VAL;
      bsr_d    = cap_vec;
    end else if (tap_q == TAP_SH_DR) begin
      bypass_d = tdi;
      id_d     = {tdi, id_q[ID_W-1:1]};
      bsr_d    = {tdi, bsr_q[BW-1:1]};
    end
    if (tap_q == TAP_UP_DR && sel_bsr) begin
      upd_d = bsr_q;
    end
  end

  // Serial output value, driven only in the two shift states.
  always_comb begin : tdo_next
    tdo_d      = 1'b0;
    tdo_oe_n_d = 1'b1;
    if (tap_q == TAP_SH_IR) begin
      tdo_d      = ir_sh_q[0];
      tdo_oe_n_d = 1'b0;
    end else if (tap_q == TAP_SH_DR) begin
      tdo_d      = sel_bsr ? bsr_q[0] : (sel_id ? id_q[0] : bypass_q);
      tdo_oe_n_d = 1'b0;
    end
  end

  // Test clock rising-edge state.
  always_ff @(posedge tck or posedge tck_rst) begin
    if (tck_rst) begin
      tap_q    <= TAP_TLR;
      ir_sh_q  <= IR_CAPTURE;
      ir_q     <= OP_IDCODE;
      tog_q    <= 1'b0;
      sample_q <= 1'b0;
      cfgio_q  <= 1'b0;
      drive_q  <= 1'b0;
      highz_q  <= 1'b0;
      bypass_q <= 1'b0;
      id_q     <= '0;
      bsr_q    <= '0;
      upd_q    <= '1;
    end else begin
      tap_q    <= tap_d;
      ir_sh_q  <= ir_sh_d;
      ir_q     <= ir_d;
      tog_q    <= tog_d;
      sample_q <= sample_d;
      cfgio_q  <= cfgio_d;
      drive_q  <= drive_d;
      highz_q  <= highz_d;
      bypass_q <= bypass_d;
      id_q     <= id_d;
      bsr_q    <= bsr_d;
      upd_q    <= upd_d;
    end
  end

  // Serial output changes on the falling test clock edge.
  always_ff @(negedge tck or posedge tck_rst) begin
    if (tck_rst) begin
      tdo_q      <= 1'b0;
      tdo_oe_n_q <= 1'b1;
    end else begin
      tdo_q      <= tdo_d;
      tdo_oe_n_q <= tdo_oe_n_d;
    end
  end

  assign tdo      = tdo_q;
  assign tdo_oe_n = tdo_oe_n_q;

  // Levels crossing into the test clock and system clock domains.
  bsci_sync #(.W(M2T)) u_m2t (
    .clk (tck),
    .rst (tck_rst),
    .d   ({pin_in, ibuf_q, uout_q, uoen_q}),
    .q   ({pin_in_t, ibuf_t, uout_t, uoen_t})
  );

  bsci_sync #(.W(T2M)) u_t2m (
    .clk (mclk),
    .rst (rst),
    .d   ({cfgio_q, tog_q, drive_q, highz_q, sample_q, upd_out, upd_oe_n}),
    .q   (t2m_s)
  );

  bsci_sync #(.W(P2M)) u_p2m (
    .clk (mclk),
    .rst (rst),
    .d   ({pin_in, configuration_request_pin_n, chip_wide_clear_pin_n, chip_wide_output_enable_pin}),
    .q   (p2m_s)
  );

  assign {cfgio_s, tog_s, drive_s, highz_s, sample_s, upd_out_s, upd_oe_s} = t2m_s;
  assign {pin_in_m, ncfg_s, clr_n_s, goe_s} = p2m_s;
  assign pulse = tog_s ^ tog_prev_q;

  // Configuration engine; chip clear and chip enable never enter here.
  always_comb begin : cfg_next
    cfg_d = cfg_q;
    cnt_d = cnt_q;
    unique case (cfg_q)
      CFG_IDLE: begin
        if (!cfgio_s) begin
          cfg_d = CFG_LOAD;
          cnt_d = '0;
        end
      end
      CFG_LOAD: begin
        if (cfgio_s) begin
          cfg_d = CFG_HALT;
        end else if (cnt_q == CFG_CNT_W'(CFG_CYCLES - 1)) begin
          cfg_d = CFG_DONE;
        end else begin
          cnt_d = cnt_q + CFG_CNT_W'(1);
        end
      end
      CFG_DONE, CFG_HALT: cfg_d = cfg_q;
    endcase
    if (pulse) begin
      cfg_d = CFG_LOAD;
      cnt_d = '0;
    end
    if (!ncfg_s) begin
      cfg_d = CFG_IDLE;
      cnt_d = '0;
    end
  end

  // Pin drivers and input buffer enables.
  always_comb begin : pin_next
    if (drive_s) begin
      pout_d = upd_out_s;
      poen_d = highz_s ? '1 : upd_oe_s;
    end else if (cfg_q == CFG_DONE) begin
      pout_d = uout_q & {NPIN{clr_n_s}};
      poen_d = uoen_q | {NPIN{~goe_s}};
    end else begin
      pout_d = '0;
      poen_d = '1;
    end
    if (cfg_q == CFG_DONE && !always_q && !sample_s) begin
      ibuf_d = ~oonly_q;
    end else begin
      ibuf_d = '1;
    end
  end

  // AHB-Lite slave: zero wait states, registered read data, late write.
  assign acc = hsel & hready & htrans[HTRANS_ACT] & (hsize == HSIZE_WORD);
  assign status_w = DATA_W'({cfgio_s, drive_s, cfg_q});

  always_comb begin : bus_next
    wr_d     = acc & hwrite;
    wa_d     = acc ? haddr[ADDR_W-1:0] : wa_q;
    rd_d     = rd_q;
    always_d = always_q;
    oonly_d  = oonly_q;
    uout_d   = uout_q;
    uoen_d   = uoen_q;
    if (acc && !hwrite) begin
      unique case (haddr[ADDR_W-1:0])
        ADDR_CTRL:    rd_d = DATA_W'(always_q);
        ADDR_OUTONLY: rd_d = DATA_W'(oonly_q);
        ADDR_USEROUT: rd_d = DATA_W'(uout_q);
        ADDR_USEROE:  rd_d = DATA_W'(uoen_q);
        ADDR_STATUS:  rd_d = status_w;
        ADDR_PININ:   rd_d = DATA_W'(pin_in_m & ibuf_q);
        default:      rd_d = '0;
      endcase
    end
    if (wr_q) begin
      unique case (wa_q)
        ADDR_CTRL:    always_d = hwdata[CTRL_ALWAYS];
        ADDR_OUTONLY: oonly_d  = hwdata[NPIN-1:0];
        ADDR_USEROUT: uout_d   = hwdata[NPIN-1:0];
        ADDR_USEROE:  uoen_d   = hwdata[NPIN-1:0];
        default:      always_d = always_q;
      endcase
    end
  end

  // System clock state.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tog_prev_q <= 1'b0;
      cfg_q      <= CFG_IDLE;
      cnt_q      <= '0;
      pout_q     <= '0;
      poen_q     <= '1;
      ibuf_q     <= '1;
      always_q   <= 1'b0;
      oonly_q    <= '0;
      uout_q     <= '0;
      uoen_q     <= '1;
      wr_q       <= 1'b0;
      wa_q       <= '0;
      rd_q       <= '0;
    end else begin
      tog_prev_q <= tog_s;
      cfg_q      <= cfg_d;
      cnt_q      <= cnt_d;
      pout_q     <= pout_d;
      poen_q     <= poen_d;
      ibuf_q     <= ibuf_d;
      always_q   <= always_d;
      oonly_q    <= oonly_d;
      uout_q     <= uout_d;
      uoen_q     <= uoen_d;
      wr_q       <= wr_d;
      wa_q       <= wa_d;
      rd_q       <= rd_d;
    end
  end

  assign pin_out     = pout_q;
  assign pin_oe_n    = poen_q;
  assign pin_ibuf_en = ibuf_q;
  assign hrdata      = rd_q;
  assign hreadyout   = 1'b1;
  assign hresp       = HRESP_OKAY;

  // Checks on the test clock side.
  chk_tap_reset: assert property (@(posedge tck) disable iff (tck_rst)
    tms [*5] |=> tap_q == TAP_TLR) else $error("five high mode selects did not reset");
  chk_ir_capture: assert property (@(posedge tck) disable iff (tck_rst)
    tap_q == TAP_CAP_IR |=> ir_sh_q[1:0] == 2'b01) else $error("bad instruction capture");
  chk_bypass_path: assert property (@(posedge tck) disable iff (tck_rst)
    (ir_q == OP_BYPASS && tap_q == TAP_SH_DR) ##1 tap_q == TAP_SH_DR |-> tdo_q == $past(tdi))
    else $error("bypass bit not on serial path");
  chk_idcode_load: assert property (@(posedge tck) disable iff (tck_rst)
    ir_q == OP_IDCODE && tap_q == TAP_CAP_DR |=> id_q == IDCODE_VAL) else $error("code not loaded");

  // Checks on the system clock side.
  chk_cfg_halt: assert property (@(posedge mclk) disable iff (rst)
    cfg_q == CFG_LOAD && cfgio_s && ncfg_s && !pulse |=> cfg_q == CFG_HALT)
    else $error("configuration not halted");
  chk_cfg_undisturbed: assert property (@(posedge mclk) disable iff (rst)
    cfg_q == CFG_LOAD && !cfgio_s && ncfg_s && !pulse |=> cfg_q inside {CFG_LOAD, CFG_DONE})
    else $error("configuration disturbed");
  chk_cfg_restart: assert property (@(posedge mclk) disable iff (rst)
    pulse && ncfg_s |=> cfg_q == CFG_LOAD ##1 cnt_q == CFG_CNT_W'(1) || cfg_q != CFG_LOAD)
    else $error("configuration not restarted");
  chk_request_hold: assert property (@(posedge mclk) disable iff (rst)
    !ncfg_s |=> cfg_q == CFG_IDLE) else $error("request low did not hold idle");
  chk_pin_extest: assert property (@(posedge mclk) disable iff (rst)
    drive_s && !highz_s && !upd_oe_s[0] |=> !pin_oe_n[0] && pin_out[0] == $past(upd_out_s[0]))
    else $error("update data not driven");
  chk_ibuf_off: assert property (@(posedge mclk) disable iff (rst)
    cfg_q == CFG_DONE && !always_q && !sample_s && oonly_q[0] |=> !pin_ibuf_en[0])
    else $error("output-only input buffer on");
  chk_ibuf_sample: assert property (@(posedge mclk) disable iff (rst)
    sample_s |=> pin_ibuf_en == '1) else $error("sample left buffers off");
  chk_ibuf_always: assert property (@(posedge mclk) disable iff (rst)
    always_q |=> pin_ibuf_en == '1) else $error("always option ignored");

  cov_ir_shift: cover property (@(posedge tck) disable iff (tck_rst) tap_q == TAP_SH_IR);
  cov_cfg_halt: cover property (@(posedge mclk) disable iff (rst) cfg_q == CFG_HALT);
  cov_cfg_resume: cover property (@(posedge mclk) disable iff (rst) cfg_q == CFG_HALT ##1 cfg_q == CFG_LOAD);
  cov_cfg_done: cover property (@(posedge mclk) disable iff (rst) cfg_q == CFG_DONE);

endmodule : bsci_top
`default_nettype wire

// >>> verification/bsci_tester.sv
`timescale 1ns/10ps
`default_nettype none
module bsci_tester (
  output var  logic tck,
  output var  logic tms,
  output var  logic tdi,
  input  wire logic tdo
);
  import bsci_pkg::*;
  logic io_held;

  // The test clock is parked low between frames.
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
    io_held = 1'b0;
  end

  // One 80 ns test clock; its rising edge sits off the system clock edges, tdo is taken there.
  task automatic cyc(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    #37;
    tck = 1'b1;
    q = tdo;
    #40;
    tck = 1'b0;
    #3;
  endtask : cyc

  // Mode-select walk, LSB first; tdi toggles so no stale level lingers.
  task automatic walk(input logic [7:0] s, input int n);
    logic q;
    for (int i = 0; i < n; i++) cyc(s[i], ~tdi, q);
  endtask : walk

  // Shift n bits LSB first, then exit through update to idle.
  task automatic scan(input int n, input logic [31:0] din, output logic [31:0] dout);
    dout = '0;
    walk(8'h02, 4);
    for (int i = 0; i < n; i++) cyc(i == n - 1, din[i], dout[i]);
    walk(8'h01, 2);
  endtask : scan

  // Instruction load; returns the captured pattern.
  task automatic load_ir(input logic [9:0] op, output logic [9:0] cap);
    logic [31:0] q;
    logic [9:0]  o;
    o = op;
    if (o inside {10'h310, 10'h0C9, 10'h313, 10'h317}) o = OP_BYPASS;
    if (!io_held && !(o inside {OP_BYPASS, OP_IDCODE, OP_SAMPLE, OP_CONFIG_IO})) load_ir(OP_CONFIG_IO, cap);
    walk(8'h06, 5);
    q = '0;
    for (int i = 0; i < 10; i++) cyc(i == 9, o[i], q[i]);
    walk(8'h01, 2);
    cap = q[9:0];
    if (o == OP_CONFIG_IO) io_held = 1'b1;
    else if (o == OP_PULSE_CFG) io_held = 1'b0;
  endtask : load_ir
endmodule : bsci_tester
`default_nettype wire

// >>> verification/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import bsci_pkg::*;
  localparam int CFGN = 3000;
  logic        mclk, rst, hsel, hwrite, hreadyout, hresp, tck, tms, tdi, tdo, tdo_oe_n;
  logic        cfg_n, clr_n, chip_oe;
  logic [31:0] haddr, hwdata, hrdata, d;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [9:0]  cap;
  logic [7:0]  p_out, p_oe_n, p_ibuf;
  int          n_mismatch, compares;

  bsci_top #(.CFG_CYCLES(CFGN)) bsci_top_i (
    .mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .tck(tck), .tms(tms), .tdi(tdi), .trst_n(1'b1), .tdo(tdo),
    .tdo_oe_n(tdo_oe_n), .configuration_request_pin_n(cfg_n), .chip_wide_clear_pin_n(clr_n),
    .chip_wide_output_enable_pin(chip_oe), .pin_in(8'hA5), .pin_out(p_out),
    .pin_oe_n(p_oe_n), .pin_ibuf_en(p_ibuf));

  bsci_tester bsci_tester_i (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));

  // System clock.
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
  endtask : idle

  // Single word transfer: address phase, then data phase.
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge mclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wr ? wd : 32'h0;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    ahb(1'b0, a, 32'h0, d);
    check(d & m, e);
  endtask : rd_chk

  task automatic t_reset;
    rd_chk(ADDR_CTRL, 32'hFFFF_FFFF, 32'h0);
    rd_chk(ADDR_OUTONLY, 32'hFFFF_FFFF, 32'h0);
    rd_chk(ADDR_USEROUT, 32'hFFFF_FFFF, 32'h0);
    rd_chk(8'h18, 32'hFFFF_FFFF, 32'h0);
    rd_chk(ADDR_USEROE, 32'hFFFF_FFFF, 32'hFF);
    check(tdo_oe_n, 1);
    rd_chk(ADDR_STATUS, 32'h3, 0);
  endtask : t_reset

  task automatic t_idcode;
    bsci_tester_i.load_ir(OP_IDCODE, cap);
    check(cap[1:0], 2'b01);
    check(cap, IR_CAPTURE);
    bsci_tester_i.scan(32, 32'h0, d);
    check(d, IDCODE_DEF);
    check(tdo_oe_n, 1);
    rd_chk(ADDR_STATUS, 32'h3, 0);
  endtask : t_idcode

  task automatic t_during_load;
    logic [9:0] ops [3];
    ops = '{OP_SAMPLE, OP_IDCODE, OP_BYPASS};
    cfg_n <= 1'b1;
    idle(10);
    rd_chk(ADDR_STATUS, 32'h3, 1);
    for (int i = 0; i < 3; i++) begin
      bsci_tester_i.load_ir(ops[i], cap);
      rd_chk(ADDR_STATUS, 32'h3, 1);
    end
    bsci_tester_i.scan(8, 32'hB4, d);
    check(d[7:0], 8'h68);
  endtask : t_during_load

  task automatic t_extest;
    logic [31:0] v;
    v = '0;
    for (int i = 0; i < 8; i++) begin
      v[3*i+1] = 1'(8'h5A >> i);
      v[3*i+2] = 1'(8'hF0 >> i);
    end
    bsci_tester_i.load_ir(OP_CONFIG_IO, cap);
    idle(10);
    rd_chk(ADDR_STATUS, 32'h7, 7);
    bsci_tester_i.load_ir(OP_SAMPLE, cap);
    bsci_tester_i.scan(24, v, d);
    check(d[23:0], 24'hB2C965);
    bsci_tester_i.load_ir(OP_EXTEST, cap);
    idle(10);
    check(p_out, 8'h5A);
    check(p_oe_n, 8'hF0);
    clr_n <= 1'b0;
    chip_oe <= 1'b0;
    idle(10);
    check({p_out, p_oe_n}, 16'h5AF0);
    rd_chk(ADDR_STATUS, 32'h3, 3);
    clr_n <= 1'b1;
    chip_oe <= 1'b1;
  endtask : t_extest

  task automatic t_restart;
    bsci_tester_i.load_ir(OP_PULSE_CFG, cap);
    idle(10);
    rd_chk(ADDR_STATUS, 32'h3, 1);
    idle(CFGN - 40);
    rd_chk(ADDR_STATUS, 32'h3, 1);
    idle(60);
    rd_chk(ADDR_STATUS, 32'h3, 2);
  endtask : t_restart

  task automatic t_ibuf;
    ahb(1'b1, ADDR_OUTONLY, 32'h0F, d);
    idle(5);
    check(p_ibuf, 8'hF0);
    rd_chk(ADDR_PININ, 32'hFF, 32'hA0);
    bsci_tester_i.load_ir(OP_SAMPLE, cap);
    idle(10);
    check(p_ibuf, 8'hFF);
    bsci_tester_i.load_ir(OP_BYPASS, cap);
    idle(10);
    check(p_ibuf, 8'hF0);
    ahb(1'b1, ADDR_CTRL, 32'h1, d);
    idle(5);
    check(p_ibuf, 8'hFF);
    rd_chk(ADDR_PININ, 32'hFF, 32'hA5);
  endtask : t_ibuf

  task automatic print_verdict;
    $display("Mismatches %0d, compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : print_verdict

  // Main sequence; request pin held low for the reset and IDCODE tests.
  initial begin
    {rst, hsize} = {1'b1, HSIZE_WORD};
    {hsel, hwrite, htrans, haddr, hwdata, cfg_n} = '0;
    {clr_n, chip_oe} = 2'b11;
    idle(10);
    rst <= 1'b0;
    t_reset();
    t_idcode();
    t_during_load();
    t_extest();
    t_restart();
    t_ibuf();
    print_verdict();
  end

  // Watchdog against a hung handshake; the tests need just over a tenth of this span.
  initial begin
    #500000;
    n_mismatch++;
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
